// file: logic/dsw_map.vh
// Register map, field positions and reset values of the drive status word
// Contract
// RULE1 - Bit 0 set only with mains on, electronics ready, pulses inhibited.
// RULE2 - Bit 1 set when the switch-on request has taken effect.
// RULE3 - Bit 2 set while running and following the reference frequency.
// RULE4 - Bit 2 cleared when power stage disabled or reference not tracked.
// RULE5 - Bit 3 set while an error is detected, zero otherwise; code holds it in the fault state until a successful fault reset.
// RULE6 - Fault reset succeeds only once the error cause has gone.
// RULE7 - After error: inhibited if power stage was disabled, else operating.
// RULE8 - Bit 4 low while coast stop is commanded, high otherwise.
// RULE9 - Bit 5 low while quick stop is commanded, high otherwise.
// RULE10 - Bit 6 set exactly while in the switching-on-inhibited state.
// RULE11 - Bit 7 set while a warning is held; controller acknowledges it.
// RULE12 - Bit 8 set while speed is inside tolerance, transients tolerated.
// RULE13 - Every bit refreshed each cycle; a read returns one-cycle snapshot.
// RULE14 - Word is 16 bits, bit 0 least significant, other bits zero.
`ifndef DSW_MAP_VH
`define DSW_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DSW_OFS_STATE 4'h0
`define DSW_OFS_IRQ_STAT 4'h4
`define DSW_OFS_IRQ_MASK 4'h8
`define DSW_OFS_CTRL 4'hc

// ****************************************
// Status word bit positions
// ****************************************
`define DSW_B_RDY_ON 0
`define DSW_B_RDY_OP 1
`define DSW_B_OP_EN 2
`define DSW_B_ERR 3
`define DSW_B_NO_COAST 4
`define DSW_B_NO_QSTOP 5
`define DSW_B_INHIB 6
`define DSW_B_WARN 7
`define DSW_B_SPD_OK 8
`define DSW_WORD_W 16
`define DSW_USED_W 9

// ****************************************
// Control register fields and reset values
// ****************************************
`define DSW_C_FAULT_RST 0
`define DSW_C_WARN_ACK 1
`define DSW_MASK_RST 9'h000

// ****************************************
// Drive states
// ****************************************
`define DSW_ST_NOT_RDY 3'h0
`define DSW_ST_INHIB 3'h1
`define DSW_ST_RDY_ON 3'h2
`define DSW_ST_SW_ON 3'h3
`define DSW_ST_OP 3'h4
`define DSW_ST_FAULT 3'h5

// ****************************************
// Timing
// ****************************************
`define DSW_CLK_NS 100
`define DSW_SPD_SETTLE_NS 2000

`endif

// file: logic/dsw_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dsw_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;
  integer i;

  // First stage feeds only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level_out = lvl_q;
endmodule

// file: logic/dsw_axil.v
// AXI4-Lite slave front end with flat register access strobes
`timescale 1ns/1ps
module dsw_axil #(
  parameter AW = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_stb,
  output wire [AW-1:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  input wire wr_ok,
  output wire rd_stb,
  output wire [AW-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_ok
);
  localparam [1:0] RESP_OKAY = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;

  reg aw_have_q;
  reg w_have_q;
  reg [AW-1:0] aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;

  // Address and data are captured independently, in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_stb = aw_have_q && w_have_q;
  assign wr_addr = aw_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_stb = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= {AW{1'b0}};
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_stb) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_stb) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: logic/dsw_top.v
// Drive status word: state tracker, status bits, interrupts, AXI4-Lite regs
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dsw_map.vh"
module dsw_top #(
  parameter CLK_NS = `DSW_CLK_NS,
  parameter SPD_SETTLE_NS = `DSW_SPD_SETTLE_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire mains_on,
  input wire elec_init_done,
  input wire switch_on_req,
  input wire enable_op_req,
  input wire coast_stop_n,
  input wire quick_stop_n,
  input wire ref_tracking,
  input wire error_active,
  input wire error_cause_present,
  input wire error_kills_power,
  input wire warning_raise,
  input wire speed_in_band,
  output wire [15:0] drive_operating_state_word,
  output wire pulses_enable,
  output wire irq
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam NIN = 12;
  wire [NIN-1:0] pins_raw;
  wire [NIN-1:0] pins;
  // Stop inputs cross inverted: the zero reset of the synchroniser then
  // means no stop, so no false stop edge follows reset
  assign pins_raw = {mains_on, elec_init_done, switch_on_req,
    enable_op_req, ~coast_stop_n, ~quick_stop_n, ref_tracking,
    error_active, error_cause_present, error_kills_power,
    warning_raise, speed_in_band};

  dsw_sync #(.W(NIN)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pins_raw),
    .level_out(pins)
  );

  wire s_mains = pins[11];
  wire s_init = pins[10];
  wire s_swon = pins[9];
  wire s_enop = pins[8];
  wire s_nocoast = !pins[7];
  wire s_noqstop = !pins[6];
  wire s_track = pins[5];
  wire s_err = pins[4];
  wire s_cause = pins[3];
  wire s_kill = pins[2];
  wire s_warn = pins[1];
  wire s_spd = pins[0];

  // ****************************************
  // Register bus
  // ****************************************
  wire wr_stb;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_stb;
  wire [3:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_ok;
  wire wr_ok;

  dsw_axil #(.AW(4)) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  wire wr_mask = wr_stb && wr_addr == `DSW_OFS_IRQ_MASK;
  wire wr_ctrl = wr_stb && wr_addr == `DSW_OFS_CTRL;
  assign wr_ok = wr_addr == `DSW_OFS_IRQ_MASK || wr_addr == `DSW_OFS_CTRL;
  wire fault_rst_pls = wr_ctrl && wr_strb[0] && wr_data[`DSW_C_FAULT_RST];
  wire warn_ack_pls = wr_ctrl && wr_strb[0] && wr_data[`DSW_C_WARN_ACK];
  wire rd_irq_stat = rd_stb && rd_addr == `DSW_OFS_IRQ_STAT;

  // ****************************************
  // Drive state machine
  // ****************************************
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg err_kill_q;

  always @* begin
    st_d = st_q;
    case (st_q)
      `DSW_ST_NOT_RDY: begin
        if (s_mains && s_init) begin
          st_d = `DSW_ST_INHIB;
        end
      end
      `DSW_ST_INHIB: begin
        if (s_nocoast && s_noqstop) begin
          st_d = `DSW_ST_RDY_ON;
        end
      end
      `DSW_ST_RDY_ON: begin
        if (s_swon) begin
          st_d = `DSW_ST_SW_ON;
        end
      end
      `DSW_ST_SW_ON: begin
        if (!s_swon) begin
          st_d = `DSW_ST_RDY_ON;
        end else if (s_enop) begin
          st_d = `DSW_ST_OP;
        end
      end
      `DSW_ST_OP: begin
        if (!s_enop) begin
          st_d = `DSW_ST_SW_ON;
        end
      end
      `DSW_ST_FAULT: begin
        // Reset only takes once the cause has gone
        if (fault_rst_pls && !s_cause) begin // [RULE6]
          st_d = err_kill_q ? `DSW_ST_INHIB : `DSW_ST_OP; // [RULE7]
        end
      end
      default: begin
        st_d = `DSW_ST_NOT_RDY;
      end
    endcase
    // Loss of supply or stop commands override the normal sequence
    if (st_q != `DSW_ST_FAULT && st_q != `DSW_ST_NOT_RDY) begin
      if (!s_mains || !s_init) begin
        st_d = `DSW_ST_NOT_RDY;
      end else if (s_err) begin
        st_d = `DSW_ST_FAULT;
      end else if (!s_nocoast || !s_noqstop) begin
        st_d = `DSW_ST_INHIB;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= `DSW_ST_NOT_RDY;
      err_kill_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q != `DSW_ST_FAULT && st_d == `DSW_ST_FAULT) begin
        err_kill_q <= s_kill;
      end
    end
  end

  // ****************************************
  // Warning latch and speed settle filter
  // ****************************************
  reg warn_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      warn_q <= 1'b0;
    end else if (s_warn) begin
      warn_q <= 1'b1; // Raise wins over acknowledge [RULE11]
    end else if (warn_ack_pls) begin
      warn_q <= 1'b0;
    end
  end

  // Short excursions out of band are ignored [RULE12]
  localparam integer SETTLE_CYC = (SPD_SETTLE_NS / CLK_NS) < 1 ? 1 :
    (SPD_SETTLE_NS / CLK_NS);
  reg [15:0] spd_cnt_q;
  reg spd_ok_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      spd_cnt_q <= 16'h0000;
      spd_ok_q <= 1'b0;
    end else if (s_spd) begin
      spd_cnt_q <= 16'h0000;
      spd_ok_q <= 1'b1;
    end else if (spd_cnt_q >= SETTLE_CYC[15:0] - 16'h0001) begin
      spd_ok_q <= 1'b0;
    end else begin
      spd_cnt_q <= spd_cnt_q + 16'h0001;
    end
  end

  // ****************************************
  // Status word, refreshed every cycle
  // ****************************************
  reg [`DSW_USED_W-1:0] word_q;
  wire [`DSW_USED_W-1:0] word_d;
  assign word_d[`DSW_B_RDY_ON] = s_mains && s_init && // [RULE1]
    (st_q == `DSW_ST_RDY_ON || st_q == `DSW_ST_SW_ON);
  assign word_d[`DSW_B_RDY_OP] = st_q == `DSW_ST_SW_ON || // [RULE2]
    st_q == `DSW_ST_OP;
  assign word_d[`DSW_B_OP_EN] = st_q == `DSW_ST_OP && // [RULE3] [RULE4]
    s_enop && s_track;
  assign word_d[`DSW_B_ERR] = st_q == `DSW_ST_FAULT; // [RULE5]
  assign word_d[`DSW_B_NO_COAST] = s_nocoast; // [RULE8]
  assign word_d[`DSW_B_NO_QSTOP] = s_noqstop; // [RULE9]
  assign word_d[`DSW_B_INHIB] = st_q == `DSW_ST_INHIB; // [RULE10]
  assign word_d[`DSW_B_WARN] = warn_q; // [RULE11]
  assign word_d[`DSW_B_SPD_OK] = spd_ok_q; // [RULE12]

  always @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= {`DSW_USED_W{1'b0}};
    end else begin
      word_q <= word_d; // [RULE13]
    end
  end

  // Unused upper positions stay zero [RULE14]
  assign drive_operating_state_word =
    {{(`DSW_WORD_W-`DSW_USED_W){1'b0}}, word_q};
  assign pulses_enable = word_q[`DSW_B_OP_EN];

  // ****************************************
  // Interrupts: any status bit change is an event
  // ****************************************
  reg [`DSW_USED_W-1:0] mask_q;
  reg [`DSW_USED_W-1:0] ists_q;
  // The first cycle after reset loads word_q from zero; that is no event
  reg run_q;
  wire [`DSW_USED_W-1:0] ev = (word_d ^ word_q) & {`DSW_USED_W{run_q}};
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= `DSW_MASK_RST;
      ists_q <= {`DSW_USED_W{1'b0}};
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
      if (wr_mask && wr_strb[0]) begin
        mask_q[7:0] <= wr_data[7:0];
      end
      if (wr_mask && wr_strb[1]) begin
        mask_q[8] <= wr_data[8];
      end
      // New events win over the read that clears
      ists_q <= (rd_irq_stat ? {`DSW_USED_W{1'b0}} : ists_q) | ev;
    end
  end
  assign irq = |(ists_q & mask_q);

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `DSW_OFS_STATE: rd_data = {16'h0000, drive_operating_state_word};
      `DSW_OFS_IRQ_STAT: rd_data = {23'h000000, ists_q};
      `DSW_OFS_IRQ_MASK: rd_data = {23'h000000, mask_q};
      `DSW_OFS_CTRL: rd_data = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end
endmodule

// file: verif/dsw_top_assertions.sv
// Checker for the status word and its pulse enable
`timescale 1ns/1ps
module dsw_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] drive_operating_state_word,
  input wire logic pulses_enable,
  input wire logic irq
);
  wire [15:0] w = drive_operating_state_word;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rsv_zero: assert property (w[15:9] == 7'h00)
    else $error("upper status bits not zero");
  a_pulse_mirror: assert property (pulses_enable == w[2])
    else $error("pulse enable differs from bit 2");
  a_op_ready: assert property (w[2] |-> w[1])
    else $error("operation enabled without ready to operate");
  a_inhib_alone: assert property (w[6] |-> !(w[0] || w[1] || w[2]))
    else $error("inhibited state shows a ready bit");
  a_pulses_off: assert property (w[0] |-> !w[2])
    else $error("ready to switch on while pulses run");
  a_err_fault: assert property (w[3] |-> !w[1] && !w[2])
    else $error("error shown while operating");
  a_coast_drop: assert property ($fell(w[4]) |-> ##[0:3] !w[2])
    else $error("coast stop left operation enabled");
  a_qstop_drop: assert property ($fell(w[5]) |-> ##[0:3] !w[1])
    else $error("quick stop left drive ready");
  c_run: cover property (w[2]);
  c_inhib: cover property (w[6]);
  c_err: cover property (w[3]);
  c_irq: cover property (irq);
endmodule

bind dsw_top dsw_top_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .drive_operating_state_word(drive_operating_state_word),
  .pulses_enable(pulses_enable),
  .irq(irq)
);

// file: verif/dsw_plant.sv
// Drive-side source model: mains, requests, stops, errors, speed
`timescale 1ns/1ps
module dsw_plant (
  input wire logic aclk,
  input wire logic [11:0] cmd,
  output logic [11:0] pins
);
  // Stops start inactive so the word leaves reset in a known state
  initial pins = 12'h030;
  // Sources move only just after an edge, like real registered outputs
  always @(posedge aclk) begin
    pins <= cmd;
  end
endmodule

// file: verif/drive_status_word_tb.sv
// Self-checking bench of the drive status word over AXI4-Lite
`timescale 1ns/1ps
module drive_status_word_tb;
  logic aclk = 0, aresetn = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0;
  logic [31:0] wdata = 0;
  logic [3:0] strb = 4'hf;
  logic [11:0] cmd = 12'h030, p;
  wire awready, wready, bvalid, arready, rvalid, pen, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] word;
  logic [65:0] q[$];
  logic [65:0] e;
  int fails = 0, cmp_count = 0, i;
  integer seed = 32'ha45c;
  logic [31:0] d;

  initial begin
    forever #50 aclk = ~aclk;
  end

  dsw_plant u_plant (.aclk(aclk), .cmd(cmd), .pins(p));

  dsw_top #(.SPD_SETTLE_NS(200)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .mains_on(p[0]), .elec_init_done(p[1]), .switch_on_req(p[2]),
    .enable_op_req(p[3]), .coast_stop_n(p[4]), .quick_stop_n(p[5]),
    .ref_tracking(p[6]), .error_active(p[7]),
    .error_cause_present(p[8]), .error_kills_power(p[9]),
    .warning_raise(p[10]), .speed_in_band(p[11]),
    .drive_operating_state_word(word), .pulses_enable(pen), .irq(irq)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Ready signals are sampled at the edge, before that edge's updates land
  task automatic wr(input logic [3:0] a, input logic [31:0] dat);
    int n;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      fails++;
      test_done();
    end
    chk({30'h0, bresp}, 32'h0);
  endtask

  // The expectation is queued; the watcher compares when data returns
  task automatic rd(input logic [3:0] a, input logic [31:0] x,
                    input logic [31:0] care, input logic [1:0] r);
    int n;
    q.push_back({care, x, r});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      fails++;
      test_done();
    end
  endtask

  task automatic st(input logic [31:0] x);
    rd(4'h0, x, 32'hffffffff, 2'b00);
  endtask

  // Inputs cross a synchroniser, so each change is given time to settle
  task automatic setw(input int b, input logic v);
    cmd[b] <= v;
    repeat (12) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (rvalid) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = q.pop_front();
        chk(rdata & e[65:34], e[33:2]);
        chk({30'h0, rresp}, {30'h0, e[1:0]});
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    st(32'h30);
    setw(0, 1);
    setw(1, 1);
    st(32'h31);
    setw(2, 1);
    st(32'h33);
    setw(6, 1);
    setw(3, 1);
    st(32'h36);
    chk({31'h0, pen}, 32'h1);
    setw(11, 1);
    st(32'h136);
    setw(11, 0);
    st(32'h36);
    setw(6, 0);
    st(32'h32);
    setw(6, 1);
    rd(4'h4, 32'h0, 32'h0, 2'b00);
    cmd[8] <= 1'b1;
    setw(7, 1);
    st(32'h38);
    wr(4'hc, 32'h1);
    st(32'h38);
    setw(8, 0);
    setw(7, 0);
    wr(4'hc, 32'h1);
    repeat (4) @(posedge aclk);
    st(32'h36);
    rd(4'h4, 32'h0, 32'h40, 2'b00);
    cmd[9] <= 1'b1;
    cmd[8] <= 1'b1;
    setw(7, 1);
    cmd[2] <= 1'b0;
    cmd[3] <= 1'b0;
    setw(8, 0);
    setw(7, 0);
    wr(4'hc, 32'h1);
    repeat (12) @(posedge aclk);
    st(32'h31);
    rd(4'h4, 32'h40, 32'h40, 2'b00);
    setw(4, 0);
    st(32'h60);
    setw(4, 1);
    setw(5, 0);
    st(32'h50);
    setw(5, 1);
    for (i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(4'h8, d);
      rd(4'h8, d & 32'h1ff, 32'hffffffff, 2'b00);
    end
    strb <= 4'h2;
    wr(4'h8, 32'h0);
    strb <= 4'hf;
    rd(4'h8, d & 32'hff, 32'hffffffff, 2'b00);
    wr(4'h8, 32'h80);
    rd(4'h4, 32'h0, 32'h0, 2'b00);
    setw(10, 1);
    setw(10, 0);
    chk({31'h0, irq}, 32'h1);
    rd(4'h4, 32'h80, 32'hffffffff, 2'b00);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    st(32'hb1);
    wr(4'hc, 32'h2);
    repeat (4) @(posedge aclk);
    st(32'h31);
    rd(4'hc, 32'h0, 32'hffffffff, 2'b00);
    rd(4'h2, 32'h0, 32'hffffffff, 2'b10);
    setw(0, 0);
    st(32'h30);
    repeat (4) @(posedge aclk);
    test_done();
  end
endmodule
